// [verilog/rsc_map.vh]
// register map, field positions, reset values and timing counts of the reset source controller
`ifndef RSC_MAP_VH
`define RSC_MAP_VH

// register indices; byte address is four times the index
`define RSC_IDX_RESET_CAUSE    16'h000B
`define RSC_IDX_WDT_OPTION     16'hFFDB
`define RSC_IDX_STARTUP_OPTION 16'hFFFF
`define RSC_IDX_PROTECT        16'h0020
`define RSC_IDX_PROC_MODE0     16'h0021
`define RSC_IDX_SUPPLY_CTRL    16'h0022
`define RSC_IDX_CLOCK_CTRL     16'h0023
`define RSC_IDX_FLASH_ERASE    16'h0024

// reset_cause_flags fields
`define RSC_CAUSE_COLD_WARM    0
`define RSC_CAUSE_PIN          1
`define RSC_CAUSE_SOFT         2
`define RSC_CAUSE_WDT          3
`define RSC_CAUSE_RSVD7        7

// protect_register / processor_mode_reg0 / other control fields
`define RSC_PROTECT_UNLOCK     1
`define RSC_PM0_SOFT_RESET     3
`define RSC_SUPPLY_RESET_EN    0
`define RSC_CLOCK_LOCO_DIV1    0
`define RSC_ERASE_STARTUP      0
`define RSC_ERASE_WDT          1

// startup_option_byte fields
`define RSC_OPT_WDT_AUTOSTART  0
`define RSC_OPT_PROTECT_SEL    2
`define RSC_OPT_PROTECT_DIS    3
`define RSC_OPT_THRESH_LO      4
`define RSC_OPT_THRESH_HI      5
`define RSC_OPT_SUPPLY_START   6
`define RSC_OPT_CSPROT_INIT    7

// watchdog_option_byte fields
`define RSC_OPT2_UFLOW_LO      0
`define RSC_OPT2_UFLOW_HI      1
`define RSC_OPT2_WINDOW_LO     2
`define RSC_OPT2_WINDOW_HI     3

// reset values
`define RSC_ERASED_BYTE        8'hFF
`define RSC_CAUSE_RESET        8'h00

// timing
`define RSC_POR_LOCO_COUNT     6'h20
`define RSC_RST_STRETCH        5'h10

`endif

// [verilog/rsc_reset_ctrl.v]
// reset source controller: cause merge, cause flags, option byte decode
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.vh"

module rsc_reset_ctrl (
  // clock and power-up reset
  input  wire        mclk,
  input  wire        sys_rst,
  // avalon-mm slave
  input  wire [17:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // reset sources
  input  wire        ext_reset_n,
  input  wire        supply_below_threshold,
  input  wire        lsclk_in,
  input  wire        wdt_underflow,
  input  wire        wdt_reset_select,
  // merged reset and start-up state
  output reg         cpu_rst,
  output reg         reset_vector_fetch,
  output reg         cpu_clk_loco_div1,
  // decoded options
  output reg  [1:0]  detect_threshold_zero,
  output reg         supply_monitor_active,
  output reg         watchdog_autostart_select,
  output reg         code_protect_active,
  output reg         count_source_protect_init,
  output reg  [1:0]  wdt_underflow_sel,
  output reg  [1:0]  refresh_window_sel
);

  // input synchronisers
  reg        pin_meta_reg;
  reg        pin_sync_reg;
  reg        vlow_meta_reg;
  reg        vlow_sync_reg;
  reg        ls_meta_reg;
  reg        ls_sync_reg;
  reg        ls_prev_reg;

  // registers
  reg        cold_warm_start_flag_reg;
  reg        pin_reset_seen_reg;
  reg        soft_reset_seen_reg;
  reg        watchdog_reset_seen_reg;
  reg        cause_rsvd7_reg;
  reg [7:0]  startup_option_byte_reg;
  reg [7:0]  watchdog_option_byte_reg;
  reg        mode_reg_write_unlock_reg;
  reg        software_reset_request_bit_reg;
  reg        supply_monitor_reset_enable_reg;

  // reset sequencing
  reg        por_hold_reg;
  reg [5:0]  por_count_reg;
  reg [4:0]  stretch_reg;
  reg        rst_stage_reg;

  wire        pin_event;
  wire        supply_event;
  wire        wdt_event;
  wire        soft_event;
  wire        cause_any;
  wire        ls_rise;
  wire [15:0] idx;
  wire        access;
  wire        wr_en;
  wire        rd_lo;
  wire [7:0]  wbyte;
  reg  [7:0]  rd_byte;

  assign idx    = avs_address[17:2];
  assign access = (avs_read | avs_write) & avs_waitrequest;
  assign wr_en  = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign rd_lo  = avs_byteenable[0];
  assign wbyte  = avs_writedata[7:0];
  assign ls_rise = ls_sync_reg & ~ls_prev_reg;

  assign pin_event    = ~pin_sync_reg;
  assign supply_event = vlow_sync_reg
                        & supply_monitor_reset_enable_reg;
  assign wdt_event    = wdt_underflow & wdt_reset_select;
  assign soft_event   = software_reset_request_bit_reg;
  assign cause_any    = pin_event | supply_event | wdt_event
                        | soft_event | por_hold_reg;

  // pin, supply and slow oscillator each cross into mclk through two stages
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      // idle level of the pin, so release of power-up reset shows no pin cause
      pin_meta_reg  <= 1'b1;
      pin_sync_reg  <= 1'b1;
      vlow_meta_reg <= 1'b1;
      vlow_sync_reg <= 1'b1;
      ls_meta_reg   <= 1'b0;
      ls_sync_reg   <= 1'b0;
      ls_prev_reg   <= 1'b0;
    end else begin
      pin_meta_reg  <= ext_reset_n;
      pin_sync_reg  <= pin_meta_reg;
      vlow_meta_reg <= supply_below_threshold;
      vlow_sync_reg <= vlow_meta_reg;
      ls_meta_reg   <= lsclk_in;
      ls_sync_reg   <= ls_meta_reg;
      ls_prev_reg   <= ls_sync_reg;
    end
  end

  // power-up and supply-drop hold: count slow clocks once supply is good
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      por_hold_reg  <= 1'b1;
      por_count_reg <= 6'h00;
    end else if (supply_event) begin
      por_hold_reg  <= 1'b1;
      por_count_reg <= 6'h00;
    end else if (por_hold_reg & ~vlow_sync_reg & ls_rise) begin
      if (por_count_reg == `RSC_POR_LOCO_COUNT - 6'h01) begin
        por_hold_reg  <= 1'b0;
        por_count_reg <= 6'h00;
      end else begin
        por_count_reg <= por_count_reg + 6'h01;
      end
    end
  end

  // stretch then release through a second flop so the cpu sees a clean edge
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stretch_reg        <= `RSC_RST_STRETCH;
      rst_stage_reg      <= 1'b1;
      cpu_rst            <= 1'b1;
      reset_vector_fetch <= 1'b0;
    end else begin
      if (cause_any) begin
        stretch_reg <= `RSC_RST_STRETCH;
      end else if (stretch_reg != 5'h00) begin
        stretch_reg <= stretch_reg - 5'h01;
      end
      rst_stage_reg      <= cause_any | (stretch_reg != 5'h00);
      cpu_rst            <= rst_stage_reg;
      reset_vector_fetch <= cpu_rst & ~rst_stage_reg;
    end
  end

  // cause flags survive the cpu reset; only power-up and a monitored supply drop clear them all
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cold_warm_start_flag_reg <= 1'b0;
    end else if (supply_event) begin
      // flag keeps its value when the monitor is off; nothing defines it
      cold_warm_start_flag_reg <= 1'b0;
    end else if (wr_en && idx == `RSC_IDX_RESET_CAUSE &&
                 wbyte[`RSC_CAUSE_COLD_WARM]) begin
      cold_warm_start_flag_reg <= 1'b1;
    end
  end

  // reserved top bit only stores what software writes
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cause_rsvd7_reg <= 1'b0;
    end else if (wr_en && idx == `RSC_IDX_RESET_CAUSE) begin
      cause_rsvd7_reg <= wbyte[`RSC_CAUSE_RSVD7];
    end
  end

  // a new cause sets its own flag and clears the other two
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_reset_seen_reg <= 1'b0;
    end else if (supply_event) begin
      pin_reset_seen_reg <= 1'b0;
    end else if (pin_event | soft_event | wdt_event) begin
      pin_reset_seen_reg <= pin_event;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      soft_reset_seen_reg <= 1'b0;
    end else if (supply_event) begin
      soft_reset_seen_reg <= 1'b0;
    end else if (pin_event | soft_event | wdt_event) begin
      soft_reset_seen_reg <= soft_event;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      watchdog_reset_seen_reg <= 1'b0;
    end else if (supply_event) begin
      watchdog_reset_seen_reg <= 1'b0;
    end else if (pin_event | soft_event | wdt_event) begin
      watchdog_reset_seen_reg <= wdt_event;
    end
  end

  // option bytes: flash model, erase to ones, programming only clears bits
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      startup_option_byte_reg  <= `RSC_ERASED_BYTE;
      watchdog_option_byte_reg <= `RSC_ERASED_BYTE;
    end else if (wr_en) begin
      if (idx == `RSC_IDX_FLASH_ERASE && wbyte[`RSC_ERASE_STARTUP])
        startup_option_byte_reg <= `RSC_ERASED_BYTE;
      else if (idx == `RSC_IDX_STARTUP_OPTION)
        startup_option_byte_reg <= startup_option_byte_reg & wbyte;
      if (idx == `RSC_IDX_FLASH_ERASE && wbyte[`RSC_ERASE_WDT])
        watchdog_option_byte_reg <= `RSC_ERASED_BYTE;
      else if (idx == `RSC_IDX_WDT_OPTION)
        watchdog_option_byte_reg <= watchdog_option_byte_reg & wbyte;
    end
  end

  // special registers reloaded by every internal reset; supply enable from the option byte, slow clock selected
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg_write_unlock_reg       <= 1'b0;
      software_reset_request_bit_reg  <= 1'b0;
      supply_monitor_reset_enable_reg <= 1'b0;
      cpu_clk_loco_div1               <= 1'b1;
    end else if (cpu_rst) begin
      mode_reg_write_unlock_reg       <= 1'b0;
      software_reset_request_bit_reg  <= 1'b0;
      supply_monitor_reset_enable_reg <=
        ~startup_option_byte_reg[`RSC_OPT_SUPPLY_START];
      cpu_clk_loco_div1               <= 1'b1;
    end else if (wr_en) begin
      if (idx == `RSC_IDX_PROTECT)
        mode_reg_write_unlock_reg <= wbyte[`RSC_PROTECT_UNLOCK];
      if (idx == `RSC_IDX_PROC_MODE0 && mode_reg_write_unlock_reg)
        software_reset_request_bit_reg <=
          wbyte[`RSC_PM0_SOFT_RESET];
      if (idx == `RSC_IDX_SUPPLY_CTRL)
        supply_monitor_reset_enable_reg <= wbyte[`RSC_SUPPLY_RESET_EN];
      if (idx == `RSC_IDX_CLOCK_CTRL)
        cpu_clk_loco_div1 <= wbyte[`RSC_CLOCK_LOCO_DIV1];
    end
  end

  // the threshold code reaches the detector continuously
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      detect_threshold_zero <= 2'h3;
    end else begin
      // one code serves both power-on and monitor detection
      detect_threshold_zero <= {
        startup_option_byte_reg[`RSC_OPT_THRESH_HI],
        startup_option_byte_reg[`RSC_OPT_THRESH_LO]};
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      supply_monitor_active <= 1'b0;
    end else begin
      supply_monitor_active <= supply_monitor_reset_enable_reg;
    end
  end

  // the other options are latched only while the cpu is held in reset,
  // so a later flash write cannot change a running configuration
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      watchdog_autostart_select <= 1'b0;
    end else if (cpu_rst) begin
      watchdog_autostart_select <=
        ~startup_option_byte_reg[`RSC_OPT_WDT_AUTOSTART];
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      code_protect_active <= 1'b0;
    end else if (cpu_rst) begin
      code_protect_active <=
        startup_option_byte_reg[`RSC_OPT_PROTECT_SEL] &
        ~startup_option_byte_reg[`RSC_OPT_PROTECT_DIS];
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count_source_protect_init <= 1'b0;
    end else if (cpu_rst) begin
      count_source_protect_init <=
        ~startup_option_byte_reg[`RSC_OPT_CSPROT_INIT];
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wdt_underflow_sel <= 2'h3;
    end else if (cpu_rst) begin
      wdt_underflow_sel <= {
        watchdog_option_byte_reg[`RSC_OPT2_UFLOW_HI],
        watchdog_option_byte_reg[`RSC_OPT2_UFLOW_LO]};
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      refresh_window_sel <= 2'h3;
    end else if (cpu_rst) begin
      refresh_window_sel <= {
        watchdog_option_byte_reg[`RSC_OPT2_WINDOW_HI],
        watchdog_option_byte_reg[`RSC_OPT2_WINDOW_LO]};
    end
  end

  // read mux; unmapped indices read zero
  always @* begin
    rd_byte = 8'h00;
    case (idx)
      `RSC_IDX_RESET_CAUSE: begin
        rd_byte = {cause_rsvd7_reg, 3'b000, watchdog_reset_seen_reg,
                   soft_reset_seen_reg, pin_reset_seen_reg,
                   cold_warm_start_flag_reg};
      end
      `RSC_IDX_STARTUP_OPTION: begin
        rd_byte = startup_option_byte_reg;
      end
      `RSC_IDX_WDT_OPTION: begin
        rd_byte = watchdog_option_byte_reg;
      end
      `RSC_IDX_PROTECT: begin
        rd_byte = {6'h00, mode_reg_write_unlock_reg, 1'b0};
      end
      `RSC_IDX_PROC_MODE0: begin
        rd_byte = {4'h0, software_reset_request_bit_reg, 3'b000};
      end
      `RSC_IDX_SUPPLY_CTRL: begin
        rd_byte = {7'h00, supply_monitor_reset_enable_reg};
      end
      `RSC_IDX_CLOCK_CTRL: begin
        rd_byte = {7'h00, cpu_clk_loco_div1};
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // one wait cycle per access gives the read mux a full clock
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~access;
      if (access && avs_read) begin
        avs_readdata <= {24'h000000, rd_lo ? rd_byte : 8'h00};
      end
    end
  end

endmodule // rsc_reset_ctrl

`default_nettype wire

// [sim/rsc_reset_checker.sv]
// port-level assertions for the reset source controller
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_checker (
  // clock and reset
  input wire logic       mclk,
  input wire logic       sys_rst,
  // bus handshake
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  // reset sources
  input wire logic       ext_reset_n,
  input wire logic       supply_below_threshold,
  input wire logic       wdt_underflow,
  input wire logic       wdt_reset_select,
  // merged reset and decoded state
  input wire logic       cpu_rst,
  input wire logic       reset_vector_fetch,
  input wire logic       cpu_clk_loco_div1,
  input wire logic       supply_monitor_active,
  input wire logic       code_protect_active,
  input wire logic [1:0] detect_threshold_zero
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // six low samples cover the two-flop sync plus the two reset stages
  sequence s_pin_low; !ext_reset_n [*6]; endsequence
  sequence s_rst_hold; cpu_rst [*8]; endsequence
  a_pin_holds_rst: assert property (s_pin_low |-> cpu_rst)
    else $error("pin held low without cpu reset");
  a_wdt_gives_rst: assert property (wdt_underflow && wdt_reset_select
    |-> ##[1:3] cpu_rst)
    else $error("selected underflow gave no reset");
  a_supply_gives_rst: assert property (
    (supply_below_threshold && supply_monitor_active) [*6] |-> cpu_rst)
    else $error("supply drop gave no reset");
  a_rst_min_hold: assert property ($rose(cpu_rst) |-> s_rst_hold)
    else $error("cpu reset released too early");
  a_fetch_at_release: assert property ($fell(cpu_rst)
    |-> ##[0:1] reset_vector_fetch)
    else $error("no vector fetch at release");
  a_fetch_one_cycle: assert property (reset_vector_fetch
    |=> !reset_vector_fetch)
    else $error("vector fetch longer than a cycle");
  a_loco_at_release: assert property ($fell(cpu_rst)
    |-> cpu_clk_loco_div1)
    else $error("slow clock not selected at release");
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("bus answer not after one wait");
  a_bus_wait_back: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than a cycle");
  a_protect_latch: assert property ($changed(code_protect_active)
    |-> $past(cpu_rst))
    else $error("protect output moved outside reset");
  a_thresh_follows: assert property ($changed(detect_threshold_zero)
    |-> $past(avs_write) || $past(avs_write, 2))
    else $error("threshold code moved without a write");
endmodule // rsc_reset_checker
`default_nettype wire

// [sim/rsc_reset_ctrl_test.sv]
// self-checking testbench for the reset source controller
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_ctrl_test;
  logic        mclk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
  logic [17:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata;
  logic        avs_waitrequest, ext_reset_n = 1, supply_below_threshold = 0;
  logic        lsclk_in = 0, wdt_underflow = 0, wdt_reset_select = 0;
  logic        cpu_rst, reset_vector_fetch, cpu_clk_loco_div1;
  logic        supply_monitor_active, watchdog_autostart_select;
  logic        code_protect_active, count_source_protect_init;
  logic [1:0]  detect_threshold_zero, wdt_underflow_sel, refresh_window_sel;
  logic [1:0]  ls_cnt = 0;
  int          err_count = 0, cmp_count = 0;
  wire  [8:0]  opts = {watchdog_autostart_select, code_protect_active,
    count_source_protect_init, refresh_window_sel, wdt_underflow_sel,
    detect_threshold_zero};

  rsc_reset_ctrl DUT (.mclk(mclk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_reset_n(ext_reset_n), .supply_below_threshold(supply_below_threshold),
    .lsclk_in(lsclk_in), .wdt_underflow(wdt_underflow),
    .wdt_reset_select(wdt_reset_select), .cpu_rst(cpu_rst),
    .reset_vector_fetch(reset_vector_fetch),
    .cpu_clk_loco_div1(cpu_clk_loco_div1),
    .detect_threshold_zero(detect_threshold_zero),
    .supply_monitor_active(supply_monitor_active),
    .watchdog_autostart_select(watchdog_autostart_select),
    .code_protect_active(code_protect_active),
    .count_source_protect_init(count_source_protect_init),
    .wdt_underflow_sel(wdt_underflow_sel),
    .refresh_window_sel(refresh_window_sel));

  always #4 mclk = ~mclk;
  // slow oscillator at an eighth of the bus clock keeps the count short
  always @(posedge mclk) begin
    ls_cnt <= ls_cnt + 2'h1;
    if (&ls_cnt) lsclk_in <= ~lsclk_in;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one access; caller stands just after a rising edge
  task automatic bus(input logic wr, input logic [15:0] idx,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    avs_address <= {idx, 2'h0};
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    if (n == 20) begin err_count++; wrap_up(); end
    @(posedge mclk);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] e,
                    input logic [7:0] m);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q & {24'hFFFFFF, m}, {24'h0, e});
  endtask
  task automatic wait_rel;
    int n;
    for (n = 0; n < 3000 && cpu_rst !== 1'b0; n++) @(posedge mclk);
    if (n == 3000) begin err_count++; wrap_up(); end
  endtask
  task automatic soft_rst;
    wr(16'h0020, 8'h02);
    wr(16'h0021, 8'h08);
    repeat (4) @(posedge mclk);
    wait_rel();
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 0;
    @(posedge mclk);
    wait_rel();
    chk(32'(cpu_clk_loco_div1), 32'h1);
    rd(16'h000B, 8'h00, 8'hFE);
    rd(16'hFFFF, 8'hFF, 8'hFF);
    rd(16'hFFDB, 8'hFF, 8'hFF);
    chk(32'(opts), 32'h03F);
    rd(16'h0100, 8'h00, 8'hFF);
    $display("power-up test done");
    wr(16'hFFFF, 8'h16);
    wr(16'hFFDB, 8'hF6);
    repeat (3) @(posedge mclk);
    chk(32'(detect_threshold_zero), 32'h1);
    wr(16'h0021, 8'h08);
    repeat (8) @(posedge mclk);
    chk(32'(cpu_rst), 32'h0);
    soft_rst();
    rd(16'h000B, 8'h04, 8'hFF);
    chk(32'(opts), 32'h1D9);
    chk(32'(supply_monitor_active), 32'h1);
    $display("option and soft reset test done");
    wr(16'h000B, 8'h01);
    rd(16'h000B, 8'h05, 8'hFF);
    wr(16'h000B, 8'h0E);
    rd(16'h000B, 8'h05, 8'hFF);
    $display("start flag test done");
    ext_reset_n <= 0;
    repeat (10) @(posedge mclk);
    chk(32'(cpu_rst), 32'h1);
    ext_reset_n <= 1;
    repeat (4) @(posedge mclk);
    wait_rel();
    rd(16'h000B, 8'h03, 8'hFF);
    wdt_underflow <= 1;
    @(posedge mclk);
    wdt_underflow <= 0;
    repeat (8) @(posedge mclk);
    chk(32'(cpu_rst), 32'h0);
    wdt_reset_select <= 1;
    wdt_underflow <= 1;
    @(posedge mclk);
    wdt_underflow <= 0;
    wdt_reset_select <= 0;
    repeat (4) @(posedge mclk);
    wait_rel();
    rd(16'h000B, 8'h09, 8'hFF);
    supply_below_threshold <= 1;
    repeat (10) @(posedge mclk);
    chk(32'(cpu_rst), 32'h1);
    supply_below_threshold <= 0;
    repeat (4) @(posedge mclk);
    wait_rel();
    rd(16'h000B, 8'h00, 8'hFF);
    $display("reset source test done");
    wr(16'h0024, 8'h03);
    rd(16'hFFFF, 8'hFF, 8'hFF);
    rd(16'hFFDB, 8'hFF, 8'hFF);
    wr(16'hFFFF, 8'hF3);
    soft_rst();
    chk(32'(opts[8:7]), 32'h0);
    chk(32'(supply_monitor_active), 32'h0);
    supply_below_threshold <= 1;
    repeat (10) @(posedge mclk);
    chk(32'(cpu_rst), 32'h0);
    supply_below_threshold <= 0;
    $display("erase and disable test done");
    wrap_up();
  end
endmodule // rsc_reset_ctrl_test

bind rsc_reset_ctrl rsc_reset_checker u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .ext_reset_n(ext_reset_n),
  .supply_below_threshold(supply_below_threshold),
  .wdt_underflow(wdt_underflow), .wdt_reset_select(wdt_reset_select),
  .cpu_rst(cpu_rst), .reset_vector_fetch(reset_vector_fetch),
  .cpu_clk_loco_div1(cpu_clk_loco_div1),
  .supply_monitor_active(supply_monitor_active),
  .code_protect_active(code_protect_active),
  .detect_threshold_zero(detect_threshold_zero));
`default_nettype wire
